// file: design/sfcg_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
module sfcg_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Asynchronous inputs and their synchronised copies
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;

  // The first stage feeds the second stage only.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// file: design/sfcg_top.sv
// Serial command port and squib switch gating of the squib fire command gate.
//
// Function
// R1 - Sixteen-bit command words, shift register and latch.
// R2 - Ignore clock and data while deselected.
// R3 - Sample one data bit per rising clock.
// R4 - Controller starts transfer with clock high.
// R5 - Commit on select rise after sixteen clocks.
// R6 - Controller deselects after sixteenth edge.
// R7 - Wrong clock count discards word, keeps latch.
// R8 - Decode latched word into block controls.
// R9 - Fire only with command, reset, enables high.
// R10 - Reset input low forces everything off.
// R11 - Squib enable low keeps switches off.
// R12 - Fire enable low allows single switch.
// R13 - Fire enable low blocks both switches.
// R14 - All enables high drive switches as commanded.
// R15 - Latch firing current detection per loop.
// R16 - Measurement output low when selected loop fired.
// R17 - Clear detection flags on commands or reset.
// R18 - Thermal fault turns that transistor off.
// R19 - Controller limits switch on time.
// R20 - Command bits arrive most significant first.
`timescale 1ns/1ps
`include "sfcg_cfg.svh"
module sfcg_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Serial command pins
  input  wire logic        spi_clk,
  input  wire logic        chip_select_n,
  input  wire logic        serial_in,
  // Safety pins
  input  wire logic        reset_in_n,
  input  wire logic        squib_enable,
  input  wire logic        fire_enable,
  // Sensors per loop and per transistor
  input  wire logic [1:0]  loop_current_high,
  input  wire logic [1:0]  hs_overtemp,
  input  wire logic [1:0]  ls_overtemp,
  // Switch drives
  output logic      [1:0]  high_side_switch,
  output logic      [1:0]  low_side_switch,
  // Measurement and status
  output logic             measure_out,
  output logic             word_commit_strobe,
  output logic             clock_fail,
  output logic      [15:0] cmd_word
);

  localparam int NSYNC = 10;

  function automatic logic is_op(input logic [15:0] w,
                                 input logic [3:0]  op);
    is_op = (w[`SFCG_OP_POS +: 4] == op);
  endfunction

  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] pins_s;
  logic             sclk_s;
  logic             csn_s;
  logic             din_s;
  logic             ri_s;
  logic             sen_s;
  logic             fen_s;
  logic [1:0]       cur_s;
  logic             hs_ot_any;
  logic             sclk_d_reg;
  logic             csn_d_reg;
  logic [1:0]       hs_ot_s;
  logic [1:0]       ls_ot_s;
  logic [1:0]       ot_raw;
  logic [1:0]       ot_s;

  assign pins_raw = {fire_enable, squib_enable, reset_in_n, serial_in,
                     chip_select_n, spi_clk, loop_current_high,
                     hs_overtemp};
  assign ot_raw   = ls_overtemp;

  sfcg_sync #(.W(NSYNC)) u_sync_pins (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  sfcg_sync #(.W(2)) u_sync_ot (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (ot_raw),
    .sync_out (ot_s)
  );

  assign fen_s     = pins_s[9];
  assign sen_s     = pins_s[8];
  assign ri_s      = pins_s[7];
  assign din_s     = pins_s[6];
  assign csn_s     = pins_s[5];
  assign sclk_s    = pins_s[4];
  assign cur_s     = pins_s[3:2];
  assign hs_ot_s   = pins_s[1:0];
  assign ls_ot_s   = ot_s;
  assign hs_ot_any = |hs_ot_s;

  // Edge detection on the synchronised serial pins.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclk_d_reg <= 1'b1;
      csn_d_reg  <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      csn_d_reg  <= csn_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire cs_fall   = ~csn_s & csn_d_reg;
  wire cs_rise   = csn_s & ~csn_d_reg;
  wire selected  = ~csn_s;

  // Transfer state, bit count and shift register.
  sfcg_pkg::sfcg_xfer_t       xf_reg;
  sfcg_pkg::sfcg_xfer_t       xf_next;
  logic [`SFCG_CNT_W-1:0]     cnt_reg;
  logic [`SFCG_CNT_W-1:0]     cnt_next;
  sfcg_pkg::sfcg_word_t       shift_reg;
  sfcg_pkg::sfcg_word_t       shift_next;
  sfcg_pkg::sfcg_word_t       latch_reg;
  logic                       strobe_reg;
  logic                       fail_reg;

  wire take_bit  = selected & sclk_rise; // R2 R3
  wire cnt_full  = (cnt_reg == `SFCG_CNT_FULL);
  wire commit_ok = cs_rise & (xf_reg == sfcg_pkg::SFCG_XF_SHIFT) &
                   cnt_full; // R5
  wire commit_bad = cs_rise & (xf_reg != sfcg_pkg::SFCG_XF_IDLE) &
                    ~commit_ok; // R7

  always_comb begin
    xf_next    = xf_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    unique case (xf_reg)
      sfcg_pkg::SFCG_XF_IDLE: begin
        if (cs_fall) begin
          xf_next  = sfcg_pkg::SFCG_XF_SHIFT;
          cnt_next = `SFCG_CNT_RST;
        end
      end
      sfcg_pkg::SFCG_XF_SHIFT: begin
        if (cs_rise) begin
          xf_next = sfcg_pkg::SFCG_XF_IDLE;
        end else if (take_bit) begin
          shift_next = {shift_reg[14:0], din_s}; // R3 R20
          if (cnt_full) begin
            xf_next = sfcg_pkg::SFCG_XF_OVER; // R7
          end else begin
            cnt_next = cnt_reg + `SFCG_CNT_W'(1);
          end
        end
      end
      sfcg_pkg::SFCG_XF_OVER: begin
        if (cs_rise) begin
          xf_next = sfcg_pkg::SFCG_XF_IDLE;
        end
      end
      default: begin
        xf_next = sfcg_pkg::SFCG_XF_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || !ri_s) begin // R10
      xf_reg     <= sfcg_pkg::SFCG_XF_IDLE;
      cnt_reg    <= `SFCG_CNT_RST;
      shift_reg  <= `SFCG_WORD_RST;
      latch_reg  <= `SFCG_WORD_RST;
      strobe_reg <= 1'b0;
      fail_reg   <= 1'b0;
    end else begin
      xf_reg     <= xf_next;
      cnt_reg    <= cnt_next;
      shift_reg  <= shift_next;
      strobe_reg <= commit_ok;
      fail_reg   <= commit_bad;
      if (commit_ok) begin
        latch_reg <= shift_reg; // R1 R5
      end
    end
  end

  // Decoding of the latched word.
  wire        op_switch = is_op(latch_reg, `SFCG_OP_SWITCH); // R8
  wire [1:0]  req_ls    = op_switch ? {latch_reg[`SFCG_LS2_POS],
                                       latch_reg[`SFCG_LS1_POS]} : 2'b00;
  wire [1:0]  req_hs    = op_switch ? {latch_reg[`SFCG_HS2_POS],
                                       latch_reg[`SFCG_HS1_POS]} : 2'b00;
  wire        new_word  = strobe_reg;
  wire        new_det   = new_word & is_op(latch_reg, `SFCG_OP_DETECT);
  wire        new_clr   = new_word & (latch_reg == `SFCG_CLEAR_WORD);
  wire        flag_clr  = new_det | new_clr; // R17

  // Switch gating per loop.
  wire        drv_en    = ri_s & sen_s; // R10 R11
  wire [1:0]  both_req  = req_ls & req_hs;
  wire [1:0]  allow     = fen_s ? 2'b11 : ~both_req; // R12 R13 R14
  wire [1:0]  ls_next   = {2{drv_en}} & allow & req_ls & ~ls_ot_s; // R9 R18
  wire [1:0]  hs_next   = {2{drv_en}} & allow & req_hs & ~hs_ot_s; // R9 R18

  logic [1:0] ls_reg;
  logic [1:0] hs_reg;
  logic [1:0] flag_reg;
  logic [1:0] flag_next;
  logic       msel_valid_reg;
  logic       msel_reg;
  logic       mo_reg;

  assign flag_next = (flag_clr ? 2'b00 : flag_reg) |
                     (ls_reg & cur_s); // R15 R17

  always_ff @(posedge mclk) begin
    if (sys_rst || !ri_s) begin // R10 R17
      ls_reg         <= 2'b00;
      hs_reg         <= 2'b00;
      flag_reg       <= 2'b00;
      msel_valid_reg <= 1'b0;
      msel_reg       <= 1'b0;
      mo_reg         <= 1'b1;
    end else begin
      ls_reg   <= ls_next;
      hs_reg   <= hs_next;
      flag_reg <= flag_next;
      if (new_word) begin
        msel_valid_reg <= new_det;
        msel_reg       <= latch_reg[`SFCG_DSEL_POS];
      end
      mo_reg <= ~(msel_valid_reg & flag_reg[msel_reg]); // R16
    end
  end

  assign low_side_switch    = ls_reg;
  assign high_side_switch   = hs_reg;
  assign measure_out        = mo_reg;
  assign word_commit_strobe = strobe_reg;
  assign clock_fail         = fail_reg;
  assign cmd_word           = latch_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_good_frame;
    commit_ok && ri_s;
  endsequence

  sequence s_bad_frame;
    commit_bad && ri_s;
  endsequence

  a_commit_copy: assert property ( // R5
    s_good_frame |=> word_commit_strobe && cmd_word == $past(shift_reg))
    else $error("Commit did not copy the shift register.");

  a_bad_discard: assert property ( // R7
    s_bad_frame ##1 ri_s |-> !word_commit_strobe && clock_fail &&
      $stable(cmd_word))
    else $error("Bad frame changed the latched word.");

  a_idle_no_fail: assert property ( // R7
    cs_rise && xf_reg == sfcg_pkg::SFCG_XF_IDLE && ri_s |=> !clock_fail)
    else $error("Clock failure flagged outside a frame.");

  a_desel_ignore: assert property ( // R2
    csn_s && ri_s && !cs_rise |=> $stable(shift_reg) && $stable(cnt_reg))
    else $error("Deselected clock changed the shift state.");

  a_shift_msb: assert property ( // R20
    take_bit && xf_reg == sfcg_pkg::SFCG_XF_SHIFT && ri_s && !cs_rise |=>
      shift_reg[0] == $past(din_s) &&
      shift_reg[15:1] == $past(shift_reg[14:0]))
    else $error("Serial bit not shifted in at the bottom.");

  a_reset_off: assert property ( // R10
    !ri_s |=> low_side_switch == 2'b00 && high_side_switch == 2'b00 &&
      flag_reg == 2'b00 && cmd_word == `SFCG_WORD_RST)
    else $error("Reset input low left state active.");

  a_sen_off: assert property ( // R11
    !sen_s |=> (low_side_switch | high_side_switch) == 2'b00)
    else $error("Switch on while squib enable low.");

  a_no_both: assert property ( // R13
    !fen_s |=> (low_side_switch & high_side_switch) == 2'b00)
    else $error("Both switches on without fire enable.");

  a_fire_exact: assert property ( // R14
    ri_s && sen_s && fen_s && !hs_ot_any && ls_ot_s == 2'b00 |=>
      low_side_switch == $past(req_ls) && high_side_switch == $past(req_hs))
    else $error("Switches differ from command with all enables.");

  a_flag_hold: assert property ( // R15
    ri_s && !flag_clr ##1 ri_s |-> (flag_reg & $past(flag_reg)) ==
      $past(flag_reg))
    else $error("Detection flag dropped without a clear.");

  a_meas_low: assert property ( // R16
    msel_valid_reg && flag_reg[msel_reg] && ri_s ##1 ri_s |-> !measure_out)
    else $error("Measurement output not low for fired loop.");

endmodule

// file: inc/sfcg_cfg.svh
// Constants of the squib fire command gate.
`ifndef SFCG_CFG_SVH
`define SFCG_CFG_SVH

`define SFCG_WORD_BITS   16
`define SFCG_CNT_W       5
`define SFCG_CNT_FULL    5'h10
`define SFCG_CNT_RST     5'h00
`define SFCG_WORD_RST    16'h0000
`define SFCG_LOOPS       2
`define SFCG_OP_POS      12
`define SFCG_OP_SWITCH   4'h8
`define SFCG_OP_DETECT   4'hD
`define SFCG_CLEAR_WORD  16'hFFFF
`define SFCG_LS1_POS     0
`define SFCG_HS1_POS     1
`define SFCG_LS2_POS     2
`define SFCG_HS2_POS     3
`define SFCG_DSEL_POS    0
`define SFCG_SYNC_STAGES 2

`endif

// file: inc/sfcg_pkg.sv
// Types of the squib fire command gate.
package sfcg_pkg;

  typedef enum logic [1:0] {
    SFCG_XF_IDLE  = 2'b00,
    SFCG_XF_SHIFT = 2'b01,
    SFCG_XF_OVER  = 2'b11
  } sfcg_xfer_t;

  typedef logic [15:0] sfcg_word_t;

endpackage

// file: sim/sfcg_spi_master.sv
// Serial command master model that drives the command port.
`timescale 1ns/1ps
module sfcg_spi_master (
  // Serial command pins
  output logic spi_clk,
  output logic chip_select_n,
  output logic serial_in
);
  initial begin
    spi_clk = 1'b1;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // Sends a word most significant bit first with n clocks.
  task automatic send(input logic [15:0] w, input int n);
    #20 chip_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #80 spi_clk = 1'b0;
      serial_in = w[15 - (i % 16)];
      #80 spi_clk = 1'b1;
    end
    #80 chip_select_n = 1'b1;
    serial_in = ~serial_in;
  endtask
  // Toggles the clock while the port is deselected.
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      #80 spi_clk = 1'b0;
      serial_in = ~serial_in;
      #80 spi_clk = 1'b1;
    end
  endtask
endmodule

// file: sim/sfcg_top_test.sv
// Self-checking bench of the squib fire command gate.
`timescale 1ns/1ps
module sfcg_top_test;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        spi_clk, chip_select_n, serial_in;
  logic        reset_in_n, squib_enable, fire_enable, mo, stb, cfail;
  logic [1:0]  cur, hot, lot, hss, lss;
  logic [15:0] cmd, m_cmd;
  logic [3:0]  m_sw;
  logic [1:0]  m_flag;
  logic [31:0] seed = 32'h0000_003F;
  logic [31:0] r;
  int          m_sel, miscompares, samples_checked;

  always #10 mclk = ~mclk;

  sfcg_spi_master sfcg_spi_master_inst (.spi_clk(spi_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in));
  sfcg_top sfcg_top_inst (.mclk(mclk), .sys_rst(sys_rst),
    .spi_clk(spi_clk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .reset_in_n(reset_in_n),
    .squib_enable(squib_enable), .fire_enable(fire_enable),
    .loop_current_high(cur), .hs_overtemp(hot), .ls_overtemp(lot),
    .high_side_switch(hss), .low_side_switch(lss), .measure_out(mo),
    .word_commit_strobe(stb), .clock_fail(cfail), .cmd_word(cmd));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Bit 0 and 2 are the low sides, bit 1 and 3 the high sides.
  function automatic logic [3:0] exp_sw();
    logic [3:0] c;
    c = (m_cmd[15:12] == 4'h8) ? m_cmd[3:0] : 4'h0;
    if (!reset_in_n || !squib_enable) c = 4'h0;
    if (!fire_enable && c[1:0] == 2'b11) c[1:0] = 2'b00;
    if (!fire_enable && c[3:2] == 2'b11) c[3:2] = 2'b00;
    return c & ~{hot[1], lot[1], hot[0], lot[0]};
  endfunction

  task automatic miss(input string what);
    miscompares++;
    $display("MISMATCH %0t %s", $time, what);
  endtask

  task automatic chk_word(input logic [15:0] g, e, input string what);
    samples_checked++;
    if (g !== e) miss(what);
  endtask

  task automatic chk_pins(input logic [3:0] g, e, input string what);
    samples_checked++;
    if (g !== e) miss(what);
  endtask

  task automatic settle();
    repeat (6) @(negedge mclk);
    m_sw = exp_sw();
    m_flag |= {m_sw[2], m_sw[0]} & cur;
    chk_word(cmd, m_cmd, "word");
    chk_pins({hss[1], lss[1], hss[0], lss[0]}, m_sw, "switch");
    chk_pins({3'b000, mo}, {3'b000, !(m_sel >= 0 && m_flag[m_sel])},
             "measure");
  endtask

  task automatic frame(input logic [15:0] w, input int n);
    int i;
    sfcg_spi_master_inst.send(w, n);
    for (i = 0; i < 20 && stb !== 1'b1 && cfail !== 1'b1; i++)
      @(negedge mclk);
    if (i == 20) begin
      miss("no frame result");
      complete_run();
    end
    chk_pins({2'b00, stb, cfail}, {2'b00, n == 16, n != 16},
             "strobe");
    if (n == 16 && (w == 16'hFFFF || w[15:12] == 4'hD))
      m_flag = {m_sw[2], m_sw[0]} & cur;
    if (n == 16) m_sel = (w[15:12] == 4'hD) ? int'(w[0]) : -1;
    if (n == 16) m_cmd = w;
    settle();
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    {reset_in_n, squib_enable, fire_enable} = 3'b100;
    {cur, hot, lot} = 6'b00_0000;
    {m_cmd, m_sw, m_flag} = {16'h0000, 4'h0, 2'b00};
    m_sel = -1;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    settle();
    $display("test reset done");
    for (int k = 0; k < 32; k++) begin
      r = rnd();
      {squib_enable, fire_enable} = k[1:0];
      {hot, lot} = r[11:8] & {4{r[12] & r[13]}};
      frame({4'h8, r[27:16]}, 16);
    end
    $display("test gating done");
    r = rnd();
    frame(r[15:0], 15);
    frame(r[31:16], 17);
    sfcg_spi_master_inst.stray(8);
    settle();
    frame(16'h8000, 16);
    $display("test framing done");
    {squib_enable, fire_enable, hot, lot, cur} = 8'b1100_0001;
    frame(16'h8005, 16);
    frame(16'hD000, 16);
    frame(16'hD001, 16);
    cur = 2'b10;
    frame(16'h8004, 16);
    frame(16'hD001, 16);
    frame(16'hFFFF, 16);
    $display("test detect done");
    frame(16'h800F, 16);
    reset_in_n = 1'b0;
    {m_cmd, m_flag} = {16'h0000, 2'b00};
    m_sel = -1;
    settle();
    reset_in_n = 1'b1;
    settle();
    frame(16'h8001, 16);
    $display("test reset input done");
    complete_run();
  end
endmodule
